// *** aiopd_top.sv ***
`timescale 1ns/1ps
module aiopd_top #(
    parameter int HALF_MS_CYCLES = aiopd_pkg::HALF_MS_CYC,
    parameter int FREE_RUN_CYCLES = aiopd_pkg::FREE_RUN_CYC,
    parameter int CNT_W = 24
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Interrupt
    output logic irq,
    // Decoded configuration
    output logic [7:0] chan_diag_en,
    output logic diag_irq_en,
    output logic [3:0] wire_break_active,
    output logic [7:0] range_codes,
    output logic conv_tick
);
    generate
        if (CNT_W < 1 || HALF_MS_CYCLES < 1 || FREE_RUN_CYCLES < 1 ||
            64'(FREE_RUN_CYCLES) >= (64'h1 << CNT_W) ||
            64'(aiopd_pkg::LONG_CYCLE_HALVES) * 64'(HALF_MS_CYCLES) >= (64'h1 << CNT_W)) begin : g_bad
            $error("Cycle counter too narrow for the chosen periods");
        end
    endgenerate

    logic [7:0] diag_en_ff;
    logic [3:0] wb_en_ff;
    logic diag_irq_en_ff;
    logic [7:0] range_ff;
    logic [1:0] cyc_sel_ff;
    logic [3:0] cyc_code_ff;
    logic [aiopd_pkg::ST_W-1:0] status_ff;
    logic [aiopd_pkg::ST_W-1:0] mask_ff;
    logic dp_wr_ff;
    logic [3:0] dp_idx_ff;
    logic check_ff;
    logic rsvd_bad_ff;
    logic restart_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;
    logic irq_ff;
    logic [3:0] wb_act_ff;
    logic tick_out_ff;
    logic addr_ok;
    logic addr_phase;
    logic [3:0] addr_idx;
    logic [7:0] wbyte;
    logic [3:0] deact;
    logic [3:0] wb_act;
    logic [CNT_W-1:0] nxt_period;
    logic code_valid;
    logic tick;
    logic cfg_bad;
    logic [aiopd_pkg::ST_W-1:0] nxt_events;
    logic [aiopd_pkg::ST_W-1:0] nxt_clear;
    logic [31:0] nxt_rdata;

    assign addr_phase = hsel && htrans[1] && hready;
    assign addr_ok = (haddr[31:6] == 26'h0) && (haddr[5:2] <= aiopd_pkg::IDX_STATE);
    assign addr_idx = haddr[5:2];
    assign wbyte = hwdata[7:0];

    // Zero-wait slave: address captured now, write data taken next cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_wr_ff <= 1'b0;
            dp_idx_ff <= 4'h0;
        end else if (ce) begin
            dp_wr_ff <= addr_phase && hwrite && addr_ok;
            dp_idx_ff <= addr_idx;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            diag_en_ff <= 8'h00;
            wb_en_ff <= 4'h0;
            diag_irq_en_ff <= 1'b0;
            range_ff <= {4{aiopd_pkg::RANGE_RESET}};
            cyc_sel_ff <= aiopd_pkg::SEL_NONE;
            cyc_code_ff <= aiopd_pkg::CODE_FREE;
            mask_ff <= '0;
        end else if (ce && dp_wr_ff) begin
            unique case (dp_idx_ff)
                aiopd_pkg::IDX_DIAG_EN: begin
                    diag_en_ff <= wbyte;
                end
                aiopd_pkg::IDX_WIREBREAK: begin
                    diag_irq_en_ff <= wbyte[aiopd_pkg::DIAG_IRQ_BIT];
                    wb_en_ff <= wbyte[3:0];
                end
                aiopd_pkg::IDX_RANGE_LOW: begin
                    range_ff[3:0] <= {wbyte[5:4], wbyte[1:0]};
                end
                aiopd_pkg::IDX_RANGE_HIGH: begin
                    range_ff[7:4] <= {wbyte[5:4], wbyte[1:0]};
                end
                aiopd_pkg::IDX_CYC_SEL: begin
                    cyc_sel_ff <= wbyte[1:0];
                end
                aiopd_pkg::IDX_CYC_TIME: begin
                    cyc_code_ff <= wbyte[3:0];
                end
                aiopd_pkg::IDX_MASK: begin
                    mask_ff <= wbyte[aiopd_pkg::ST_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Reserved bytes are never stored; only their written value is judged
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            check_ff <= 1'b0;
            rsvd_bad_ff <= 1'b0;
            restart_ff <= 1'b0;
        end else if (ce) begin
            check_ff <= dp_wr_ff;
            rsvd_bad_ff <= dp_wr_ff && (wbyte != 8'h00) &&
                ((dp_idx_ff == aiopd_pkg::IDX_RSVD_A) || (dp_idx_ff == aiopd_pkg::IDX_RSVD_B));
            restart_ff <= dp_wr_ff && (dp_idx_ff == aiopd_pkg::IDX_CYC_TIME);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ch
            aiopd_range_dec u_dec (
                .range_code(range_ff[2*gi+1:2*gi]),
                .wb_enable(wb_en_ff[gi]),
                .deactivated(deact[gi]),
                .wb_active(wb_act[gi])
            );
        end
    endgenerate

    // Codes 2..5 stop the timer rather than guess a period
    always_comb begin
        code_valid = 1'b1;
        if (cyc_code_ff == aiopd_pkg::CODE_FREE) begin
            nxt_period = CNT_W'(FREE_RUN_CYCLES);
        end else if (cyc_code_ff == aiopd_pkg::CODE_16MS) begin
            nxt_period = CNT_W'(aiopd_pkg::LONG_CYCLE_HALVES * HALF_MS_CYCLES);
        end else if (cyc_code_ff >= aiopd_pkg::CODE_MIN_STEP) begin
            nxt_period = CNT_W'(32'(cyc_code_ff) * 32'(HALF_MS_CYCLES));
        end else begin
            nxt_period = CNT_W'(FREE_RUN_CYCLES);
            code_valid = 1'b0;
        end
    end

    aiopd_cycle_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .period(nxt_period),
        .run(code_valid),
        .restart(restart_ff),
        .tick(tick)
    );

    // Illegal combinations flag an error; the selected event is withheld and codes 2..5 stop the timer
    assign cfg_bad = !code_valid ||
        ((cyc_sel_ff == aiopd_pkg::SEL_TIMED) && (cyc_code_ff == aiopd_pkg::CODE_FREE)) ||
        ((cyc_sel_ff == aiopd_pkg::SEL_CYC_END) && (|deact)) ||
        (cyc_sel_ff == 2'h3);

    always_comb begin
        nxt_events = '0;
        nxt_events[aiopd_pkg::ST_PARAM_ERR] = rsvd_bad_ff || (check_ff && cfg_bad);
        nxt_events[aiopd_pkg::ST_TIMED] = tick && (cyc_sel_ff == aiopd_pkg::SEL_TIMED) &&
            (cyc_code_ff != aiopd_pkg::CODE_FREE);
        nxt_events[aiopd_pkg::ST_CYC_END] = tick && (cyc_sel_ff == aiopd_pkg::SEL_CYC_END) && !(|deact);
        nxt_clear = '0;
        if (addr_phase && !hwrite && addr_ok && (addr_idx == aiopd_pkg::IDX_STATUS)) begin
            nxt_clear = '1;
        end
    end

    // Set beats clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_ff <= '0;
        end else if (ce) begin
            status_ff <= (status_ff & ~nxt_clear) | nxt_events;
        end
    end

    always_comb begin
        nxt_rdata = 32'h0;
        unique case (addr_idx)
            aiopd_pkg::IDX_DIAG_EN: nxt_rdata[7:0] = diag_en_ff;
            aiopd_pkg::IDX_WIREBREAK: nxt_rdata[7:0] = {3'h0, diag_irq_en_ff, wb_en_ff};
            aiopd_pkg::IDX_RANGE_LOW: nxt_rdata[7:0] = {2'h0, range_ff[3:2], 2'h0, range_ff[1:0]};
            aiopd_pkg::IDX_RANGE_HIGH: nxt_rdata[7:0] = {2'h0, range_ff[7:6], 2'h0, range_ff[5:4]};
            aiopd_pkg::IDX_CYC_SEL: nxt_rdata[7:0] = {6'h0, cyc_sel_ff};
            aiopd_pkg::IDX_CYC_TIME: nxt_rdata[7:0] = {4'h0, cyc_code_ff};
            aiopd_pkg::IDX_STATUS: nxt_rdata[aiopd_pkg::ST_W-1:0] = status_ff;
            aiopd_pkg::IDX_MASK: nxt_rdata[aiopd_pkg::ST_W-1:0] = mask_ff;
            aiopd_pkg::IDX_STATE: nxt_rdata[9:0] = {code_valid, cfg_bad, deact, wb_act};
            default: nxt_rdata = 32'h0;
        endcase
        if (!addr_ok) begin
            nxt_rdata = 32'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_ff <= 32'h0;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end else if (ce) begin
            hreadyout_ff <= 1'b1;
            // Only OKAY is ever answered; unmapped accesses read zero instead
            hresp_ff <= 1'b0;
            if (addr_phase && !hwrite) begin
                hrdata_ff <= nxt_rdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
            wb_act_ff <= 4'h0;
            tick_out_ff <= 1'b0;
        end else if (ce) begin
            irq_ff <= |(status_ff & mask_ff);
            wb_act_ff <= wb_act;
            tick_out_ff <= tick;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign irq = irq_ff;
    assign chan_diag_en = diag_en_ff;
    assign diag_irq_en = diag_irq_en_ff;
    assign wire_break_active = wb_act_ff;
    assign range_codes = range_ff;
    assign conv_tick = tick_out_ff;

    // Checking helpers
    logic [31:0] gap_ff;
    logic armed_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_ff <= 32'h0;
            armed_ff <= 1'b0;
        end else if (ce) begin
            gap_ff <= (tick || restart_ff) ? 32'h1 : gap_ff + 32'h1;
            armed_ff <= restart_ff ? 1'b0 : (armed_ff || tick);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_diag_store: assert property (ce && dp_wr_ff && dp_idx_ff == aiopd_pkg::IDX_DIAG_EN ##1 ce
        |-> chan_diag_en == $past(hwdata[7:0])) else $error("Diag enables not stored");
    chk_wb_range: assert property (wire_break_active[0] |-> $past(range_ff[1:0]) == aiopd_pkg::RANGE_LOOP)
        else $error("Wire-break active outside current loop");
    chk_rsvd_flag: assert property (ce [*3] ##0
        ($past(dp_wr_ff, 2) && $past(dp_idx_ff, 2) == aiopd_pkg::IDX_RSVD_A && $past(hwdata[7:0], 2) != 8'h00)
        |-> status_ff[aiopd_pkg::ST_PARAM_ERR]) else $error("Reserved write not flagged");
    chk_range_read: assert property (ce && addr_phase && !hwrite && addr_idx == aiopd_pkg::IDX_RANGE_LOW
        |=> hrdata[7:6] == 2'h0 && hrdata[3:2] == 2'h0 && hrdata[1:0] == $past(range_ff[1:0]))
        else $error("Range read wrong");
    chk_timed_cause: assert property ($rose(status_ff[aiopd_pkg::ST_TIMED])
        |-> $past(cyc_sel_ff) == aiopd_pkg::SEL_TIMED && $past(cyc_code_ff) != aiopd_pkg::CODE_FREE)
        else $error("Time-cyclic event without cause");
    chk_cycend_cause: assert property ($rose(status_ff[aiopd_pkg::ST_CYC_END])
        |-> $past(tick) && $past(deact) == 4'h0) else $error("Cycle-end event with input off");
    chk_free_period: assert property (ce && tick && armed_ff && cyc_code_ff == aiopd_pkg::CODE_FREE
        && $stable(cyc_code_ff) |-> gap_ff == 32'(FREE_RUN_CYCLES)) else $error("Free-run period wrong");
    chk_step_period: assert property (ce && tick && armed_ff && cyc_code_ff >= aiopd_pkg::CODE_MIN_STEP
        && $stable(cyc_code_ff) |-> gap_ff == 32'(cyc_code_ff) * 32'(HALF_MS_CYCLES))
        else $error("Stepped period wrong");
    chk_bad_code: assert property (cyc_code_ff inside {[4'h2:4'h5]} [*2] |-> !tick)
        else $error("Timer runs on invalid code");
    chk_irq_level: assert property (ce && (status_ff & mask_ff) != '0 |=> irq)
        else $error("Interrupt not raised");
    chk_status_clear: assert property (ce && nxt_clear[0] && nxt_events == '0 |=> status_ff == '0)
        else $error("Status not cleared by read");

    cov_reserved_err: cover property (rsvd_bad_ff ##1 status_ff[aiopd_pkg::ST_PARAM_ERR]);
    cov_timed_irq: cover property (status_ff[aiopd_pkg::ST_TIMED] && mask_ff[aiopd_pkg::ST_TIMED] ##1 irq);
    cov_cycle_end: cover property ($rose(status_ff[aiopd_pkg::ST_CYC_END]));
    cov_wire_break: cover property (wire_break_active != 4'h0);
    cov_free_run: cover property (tick && armed_ff && cyc_code_ff == aiopd_pkg::CODE_FREE);
endmodule

// *** aiopd_pkg.sv ***
// How it works
// - Eight channel diag enables, module interrupt enable.
// - Wire-break only acts in 4-20 mA range.
// - Nonzero reserved byte write flags assignment error.
// - Two-bit range per input, default plus/minus 10 V.
// - Time-cyclic interrupt needs cycle code not one.
// - Cycle-end interrupt needs no deactivated input.
// - Cycle code 0 is 16 ms, 1 free-running.
// - Codes 6..15 give code times half millisecond.
package aiopd_pkg;
    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_DIAG_EN = 4'h0;
    localparam logic [3:0] IDX_WIREBREAK = 4'h1;
    localparam logic [3:0] IDX_RSVD_A = 4'h2;
    localparam logic [3:0] IDX_RSVD_B = 4'h3;
    localparam logic [3:0] IDX_RANGE_LOW = 4'h4;
    localparam logic [3:0] IDX_RANGE_HIGH = 4'h5;
    localparam logic [3:0] IDX_CYC_SEL = 4'h6;
    localparam logic [3:0] IDX_CYC_TIME = 4'h7;
    localparam logic [3:0] IDX_STATUS = 4'h8;
    localparam logic [3:0] IDX_MASK = 4'h9;
    localparam logic [3:0] IDX_STATE = 4'ha;
    // Field layout
    localparam int DIAG_IRQ_BIT = 4;
    localparam logic [7:0] WIREBREAK_MASK = 8'h1f;
    localparam logic [7:0] RANGE_MASK = 8'h33;
    localparam logic [7:0] CYC_SEL_MASK = 8'h03;
    localparam logic [7:0] CYC_TIME_MASK = 8'h0f;
    // Reset values
    localparam logic [1:0] RANGE_RESET = 2'h1;
    localparam logic [3:0] CYC_CODE_RESET = 4'h1;
    // Encodings
    localparam logic [1:0] RANGE_OFF = 2'h0;
    localparam logic [1:0] RANGE_LOOP = 2'h3;
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_TIMED = 2'h1;
    localparam logic [1:0] SEL_CYC_END = 2'h2;
    localparam logic [3:0] CODE_16MS = 4'h0;
    localparam logic [3:0] CODE_FREE = 4'h1;
    localparam logic [3:0] CODE_MIN_STEP = 4'h6;
    // Status bits
    localparam int ST_PARAM_ERR = 0;
    localparam int ST_TIMED = 1;
    localparam int ST_CYC_END = 2;
    localparam int ST_W = 3;
    // Timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int HALF_MS_PS = 500000000;
    localparam int HALF_MS_CYC = HALF_MS_PS / CLK_PERIOD_PS;
    localparam int LONG_CYCLE_MS = 16;
    localparam int LONG_CYCLE_HALVES = LONG_CYCLE_MS * 2;
    localparam int FREE_RUN_CYC = 1000;
endpackage

// *** aiopd_range_dec.sv ***
`timescale 1ns/1ps
module aiopd_range_dec (
    // Per-input configuration
    input wire logic [1:0] range_code,
    input wire logic wb_enable,
    // Decoded state
    output logic deactivated,
    output logic wb_active
);
    assign deactivated = (range_code == aiopd_pkg::RANGE_OFF);
    // Enable alone is not enough; range must be the current loop
    assign wb_active = wb_enable && (range_code == aiopd_pkg::RANGE_LOOP);
endmodule

// *** aiopd_cycle_timer.sv ***
`timescale 1ns/1ps
module aiopd_cycle_timer #(
    parameter int CNT_W = 24
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Control
    input wire logic [CNT_W-1:0] period,
    input wire logic run,
    input wire logic restart,
    // Cycle end
    output logic tick
);
    logic [CNT_W-1:0] cnt_ff;
    logic tick_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else if (ce) begin
            if (restart || !run) begin
                cnt_ff <= period - 1'b1;
                tick_ff <= 1'b0;
            end else if (cnt_ff == '0) begin
                cnt_ff <= period - 1'b1;
                tick_ff <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff - 1'b1;
                tick_ff <= 1'b0;
            end
        end
    end

    assign tick = tick_ff;
endmodule

// *** tb_aiopd_top.sv ***
`timescale 1ns/1ps
`define CHK(act, exp, msg) begin samples_checked++; if ((act) !== (exp)) begin failures++; $display("BAD %0t %s", $time, msg); end end
module tb_aiopd_top;
    // Short half millisecond keeps the run small
    localparam int HALF = 4;
    localparam int FREE = 7;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, irq, diag_irq_en, conv_tick;
    logic [7:0] chan_diag_en, range_codes;
    logic [3:0] wire_break_active;
    logic [31:0] rd;
    int failures = 0;
    int samples_checked = 0;
    int n;

    aiopd_top #(.HALF_MS_CYCLES(HALF), .FREE_RUN_CYCLES(FREE), .CNT_W(24)) dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .chan_diag_en(chan_diag_en),
        .diag_irq_en(diag_irq_en), .wire_break_active(wire_break_active),
        .range_codes(range_codes), .conv_tick(conv_tick)
    );

    always #2 clk = ~clk;

    // Master waits on hready rather than assuming zero wait states
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rdata = hrdata;
    endtask

    task automatic wr_reg(input logic [3:0] idx, input logic [7:0] d);
        logic [31:0] x;
        xfer(1'b1, {26'h0, idx, 2'h0}, {24'h0, d}, x);
    endtask

    task automatic rd_reg(input logic [3:0] idx, output logic [31:0] d);
        xfer(1'b0, {26'h0, idx, 2'h0}, 32'h0, d);
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic chk_err(input logic exp, input string msg);
        logic [31:0] d;
        settle(4);
        rd_reg(aiopd_pkg::IDX_STATUS, d);
        `CHK(d[aiopd_pkg::ST_PARAM_ERR], exp, msg)
    endtask

    // Cycles up to the next conversion tick, bounded
    task automatic wait_tick(output int k);
        k = 0;
        do begin
            settle(1);
            k++;
        end while (conv_tick !== 1'b1 && k < 400);
        `CHK(conv_tick, 1'b1, "tick timeout")
    endtask

    task automatic t_reset;
        logic [7:0] exp_rst [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h11, 8'h00, 8'h01};
        `CHK(range_codes, 8'h55, "range reset")
        `CHK({chan_diag_en, diag_irq_en, wire_break_active, irq}, 14'h0, "enable reset")
        for (int i = 0; i < 8; i++) begin
            rd_reg(4'(i), rd);
            `CHK(rd, {24'h0, exp_rst[i]}, "register reset")
        end
        xfer(1'b1, 32'h0000_002c, 32'h0000_00ff, rd);
        xfer(1'b0, 32'h0000_002c, 32'h0, rd);
        `CHK(rd, 32'h0, "unmapped read")
        xfer(1'b0, 32'h0000_0040, 32'h0, rd);
        `CHK({rd, hresp, hreadyout}, 34'h1, "high address read")
    endtask

    task automatic t_diag;
        wr_reg(aiopd_pkg::IDX_DIAG_EN, 8'ha5);
        settle(1);
        `CHK(chan_diag_en, 8'ha5, "channel enables")
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(aiopd_pkg::IDX_DIAG_EN, 8'h3c);
        ce <= 1'b1;
        settle(1);
        `CHK(chan_diag_en, 8'ha5, "frozen by clock enable")
        wr_reg(aiopd_pkg::IDX_WIREBREAK, 8'hf0);
        settle(1);
        `CHK({diag_irq_en, wire_break_active}, 5'h10, "module enable")
        rd_reg(aiopd_pkg::IDX_WIREBREAK, rd);
        `CHK(rd, 32'h10, "unassigned bits")
        chk_err(1'b0, "false error");
    endtask

    task automatic t_wirebreak;
        wr_reg(aiopd_pkg::IDX_WIREBREAK, 8'h0f);
        settle(2);
        `CHK(wire_break_active, 4'h0, "break outside loop range")
        wr_reg(aiopd_pkg::IDX_RANGE_LOW, 8'hc3);
        settle(2);
        `CHK({range_codes, wire_break_active}, 12'h531, "input one loop")
        rd_reg(aiopd_pkg::IDX_RANGE_LOW, rd);
        `CHK(rd, 32'h03, "range unassigned bits")
        wr_reg(aiopd_pkg::IDX_RANGE_HIGH, 8'h3e);
        settle(2);
        `CHK({range_codes, wire_break_active}, 12'he39, "inputs three four")
        rd_reg(aiopd_pkg::IDX_STATE, rd);
        `CHK(rd, 32'h229, "state register")
        wr_reg(aiopd_pkg::IDX_RANGE_LOW, 8'h11);
        wr_reg(aiopd_pkg::IDX_RANGE_HIGH, 8'h11);
        settle(2);
        `CHK(wire_break_active, 4'h0, "break cleared")
    endtask

    task automatic t_reserved;
        wr_reg(aiopd_pkg::IDX_MASK, 8'h01);
        rd_reg(aiopd_pkg::IDX_STATUS, rd);
        wr_reg(aiopd_pkg::IDX_RSVD_A, 8'h00);
        chk_err(1'b0, "zero reserved write");
        wr_reg(aiopd_pkg::IDX_RSVD_B, 8'h80);
        settle(5);
        `CHK(irq, 1'b1, "irq on error")
        rd_reg(aiopd_pkg::IDX_RSVD_B, rd);
        `CHK(rd, 32'h0, "reserved reads zero")
        rd_reg(aiopd_pkg::IDX_STATUS, rd);
        `CHK(rd[0], 1'b1, "error flagged")
        settle(2);
        `CHK(irq, 1'b0, "irq after clear")
        rd_reg(aiopd_pkg::IDX_STATUS, rd);
        `CHK(rd[0], 1'b0, "status read clears")
        wr_reg(aiopd_pkg::IDX_MASK, 8'h00);
        wr_reg(aiopd_pkg::IDX_RSVD_A, 8'h01);
        settle(5);
        `CHK(irq, 1'b0, "masked error")
        chk_err(1'b1, "reserved byte a");
    endtask

    task automatic t_cycle;
        logic [7:0] cd [5] = '{8'hf0, 8'h01, 8'h06, 8'h07, 8'h0f};
        int per [5] = '{32 * HALF, FREE, 6 * HALF, 7 * HALF, 15 * HALF};
        int cnt;
        // First ticks are skipped: one may still come from the old period
        for (int i = 0; i < 5; i++) begin
            wr_reg(aiopd_pkg::IDX_CYC_TIME, cd[i]);
            wait_tick(n);
            wait_tick(n);
            wait_tick(n);
            `CHK(n, per[i], "cycle period")
        end
        for (int c = 2; c < 6; c++) begin
            wr_reg(aiopd_pkg::IDX_CYC_TIME, 8'(c));
            cnt = 0;
            repeat (150) begin
                settle(1);
                if (conv_tick === 1'b1) cnt++;
            end
            `CHK(cnt, 0, "invalid code ticks")
            chk_err(1'b1, "invalid code");
        end
    endtask

    task automatic t_cyclic;
        wr_reg(aiopd_pkg::IDX_CYC_TIME, 8'h06);
        wr_reg(aiopd_pkg::IDX_CYC_SEL, 8'h01);
        chk_err(1'b0, "timed legal");
        wr_reg(aiopd_pkg::IDX_MASK, 8'h02);
        wait_tick(n);
        settle(3);
        `CHK(irq, 1'b1, "timed irq")
        rd_reg(aiopd_pkg::IDX_STATUS, rd);
        `CHK(rd[2:1], 2'b01, "timed event")
        wr_reg(aiopd_pkg::IDX_CYC_TIME, 8'h01);
        chk_err(1'b1, "timed with free run");
        wr_reg(aiopd_pkg::IDX_CYC_TIME, 8'h06);
        wr_reg(aiopd_pkg::IDX_CYC_SEL, 8'h02);
        chk_err(1'b0, "cycle end legal");
        wait_tick(n);
        settle(3);
        rd_reg(aiopd_pkg::IDX_STATUS, rd);
        `CHK(rd[2:1], 2'b10, "cycle end event")
        wr_reg(aiopd_pkg::IDX_RANGE_HIGH, 8'h10);
        chk_err(1'b1, "cycle end with input off");
        wr_reg(aiopd_pkg::IDX_RANGE_HIGH, 8'h11);
        wr_reg(aiopd_pkg::IDX_CYC_SEL, 8'h00);
        rd_reg(aiopd_pkg::IDX_STATUS, rd);
        wait_tick(n);
        settle(3);
        rd_reg(aiopd_pkg::IDX_STATUS, rd);
        `CHK({rd[2:1], irq}, 3'b000, "no cyclic interrupt")
    endtask

    task automatic print_verdict;
        if (failures == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_diag();
        t_wirebreak();
        t_reserved();
        t_cycle();
        t_cyclic();
        print_verdict();
    end

    // Expected run is near 1700 cycles; this allows a wide margin
    initial begin
        #100000;
        failures++;
        print_verdict();
    end
endmodule
